// file: shared/sdram_pm_params.svh
// offsets, field positions, reset values and timing counts of the pm block
`ifndef SDRAM_PM_PARAMS_SVH
`define SDRAM_PM_PARAMS_SVH

`define PM_ADDR_W 12
`define PM_OFS_STATUS 12'h000
`define PM_OFS_CONFIG 12'h004
`define PM_OFS_REFRESH 12'h008

`define PM_CFG_SR_BIT 31
`define PM_CFG_PDOWN_BIT 30
`define PM_CFG_LOW_MSB 23
`define PM_CFG_RESET 32'h0000_0000

`define PM_ST_STATE_LSB 0
`define PM_ST_CKE_BIT 3
`define PM_ST_INIT_BIT 4
`define PM_ST_GATE_BIT 5
`define PM_ST_BACKLOG_LSB 8
`define PM_ST_PSC_LSB 12

`define PM_CLK_PERIOD_NS 25
`define PM_INIT_TIME_NS 200000
`define PM_RFC_TIME_NS 70
`define PM_XSR_TIME_NS 70
`define PM_REFRESH_INTERVAL_NS 15625
`define PM_ACCESS_CYCLES 4
// least times round up, the refresh interval is a longest time: round down
`define PM_CEIL_CYC(ns) (((ns) + `PM_CLK_PERIOD_NS - 1) / `PM_CLK_PERIOD_NS)
`define PM_INIT_CYCLES `PM_CEIL_CYC(`PM_INIT_TIME_NS)
`define PM_RFC_CYCLES `PM_CEIL_CYC(`PM_RFC_TIME_NS)
`define PM_XSR_CYCLES `PM_CEIL_CYC(`PM_XSR_TIME_NS)
`define PM_REFRESH_CYCLES (`PM_REFRESH_INTERVAL_NS / `PM_CLK_PERIOD_NS)

`define PM_BACKLOG_MAX 4'hf
`define PM_LVL_NEED 4'h4
`define PM_LVL_MUST 4'h7
`define PM_LVL_RELEASE 4'h2

`endif

// file: shared/sdram_pm_pkg.sv
// types shared by the memory controller power management block
package sdram_pm_pkg;
	typedef enum logic [2:0] {
		ST_INIT, ST_IDLE, ST_ACCESS, ST_REFRESH, ST_PDOWN, ST_SELF_REF,
		ST_SR_EXIT
	} core_state_t;

	// power sleep controller state as presented on the input pins
	typedef enum logic [1:0] {
		PSC_ENABLE, PSC_AUTO_SLEEP, PSC_AUTO_WAKE, PSC_SYNC_RESET
	} psc_state_t;

	typedef enum logic [2:0] {
		CMD_NOP, CMD_PRECHARGE_ALL, CMD_AUTO_REFRESH, CMD_LOAD_MODE,
		CMD_ACCESS, CMD_SELF_REF_ENTRY
	} sdram_cmd_t;

	typedef struct packed {
		logic valid;
		logic write;
	} mem_req_t;
endpackage

// file: src/refresh_tick.sv
// refresh interval divider: one-cycle tick every programmed number of cycles
`timescale 1ns/1ps
`default_nettype none
module refresh_tick #(
	parameter int RATE_W = 16
) (
	input wire logic i_clock,
	input wire logic i_nrst,
	input wire logic i_enable,
	input wire logic [RATE_W-1:0] i_rate,
	output logic o_tick
);
	logic [RATE_W-1:0] cnt_q;

	// a counter narrower than two bits cannot hold an interval
	if (RATE_W < 2) begin : g_bad_rate
		$error("refresh_tick: RATE_W too small");
	end

	// a rate of zero behaves as one so the tick never stops silently
	always_ff @(posedge i_clock) begin
		if (!i_nrst || !i_enable) begin
			cnt_q <= '0;
			o_tick <= 1'b0;
		end else if (cnt_q + 1'b1 >= i_rate) begin
			cnt_q <= '0;
			o_tick <= 1'b1;
		end else begin
			cnt_q <= cnt_q + 1'b1;
			o_tick <= 1'b0;
		end
	end
endmodule
`default_nettype wire

// file: src/sdram_pm_ctrl.sv
// power management core of the external memory controller with apb registers
//
// Contract
// - power-down mode drives the sdram clock-enable pin low
// - in power-down raise clock-enable for each due refresh, then drop
// - after power-down entry clock-enable stays low until a request, a due refresh or a config change
// - no commands reach the sdram while in self-refresh
// - four sleep controller states honoured, enable is the default
// - self-refresh waits for outstanding accesses and backlogged refreshes
// - register and memory requests are accepted during auto sleep
// - a request in auto sleep wakes, is serviced, then sleep resumes
// - sync reset leaves registers and memory contents untouched
// - during sync reset no register or memory request is serviced
// - block stays fully functional during debug halts
// - self-refresh request yields to accesses and refreshes, only power-down ranks lower
// - write to low three config bytes or reset restarts initialization
`timescale 1ns/1ps
`default_nettype none
`include "sdram_pm_params.svh"
module sdram_pm_ctrl #(
	parameter int RATE_W = 16,
	parameter int INIT_CYCLES = `PM_INIT_CYCLES,
	parameter int ACCESS_CYCLES = `PM_ACCESS_CYCLES
) (
	input wire logic i_clock,
	input wire logic i_nrst,
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [`PM_ADDR_W-1:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	input wire logic [3:0] i_pstrb,
	output logic o_pready,
	output logic [31:0] o_prdata,
	output logic o_pslverr,
	input wire sdram_pm_pkg::psc_state_t i_psc_state,
	input wire sdram_pm_pkg::mem_req_t i_mem_req,
	output logic o_mem_ack,
	output logic o_sdram_clock_enable_pin,
	output var sdram_pm_pkg::sdram_cmd_t o_sdram_cmd,
	output logic o_clock_gate_ok
);
	sdram_pm_pkg::core_state_t state_q;
	logic [31:0] cfg_q;
	logic [RATE_W-1:0] rate_q;
	logic [15:0] cnt_q;
	logic [3:0] backlog_q;
	logic must_q;
	logic init_done_q;
	logic tick;
	logic accept;
	logic apb_fire;
	logic wr_fire;
	logic init_restart;
	logic [31:0] wmask;
	logic [31:0] status;
	logic [31:0] rdata;
	logic unmapped;

	// refuse parameter values that the 16-bit counters cannot hold
	if (RATE_W < 10 || RATE_W > 16) begin : g_bad_rate
		$error("RATE_W out of range");
	end
	if (ACCESS_CYCLES < 1 || ACCESS_CYCLES > 65535) begin : g_bad_access
		$error("ACCESS_CYCLES out of range");
	end
	if (INIT_CYCLES < 1 || INIT_CYCLES > 65535) begin : g_bad_init
		$error("INIT_CYCLES out of range");
	end

	assign accept = (i_psc_state != sdram_pm_pkg::PSC_SYNC_RESET);
	assign apb_fire = i_psel && i_penable && o_pready;
	assign wr_fire = apb_fire && i_pwrite;

	assign init_restart = wr_fire && (i_paddr == `PM_OFS_CONFIG) &&
		(i_pstrb[2:0] != 3'h0);

	// byte lane mask from the apb strobes
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			wmask[i*8 +: 8] = {8{i_pstrb[i]}};
		end
	end

	// status word: core state, pin level, init, gating and pm state
	always_comb begin
		status = 32'h0000_0000;
		status[`PM_ST_STATE_LSB +: 3] = state_q;
		status[`PM_ST_CKE_BIT] = o_sdram_clock_enable_pin;
		status[`PM_ST_INIT_BIT] = init_done_q;
		status[`PM_ST_GATE_BIT] = o_clock_gate_ok;
		status[`PM_ST_BACKLOG_LSB +: 4] = backlog_q;
		status[`PM_ST_PSC_LSB +: 2] = i_psc_state;
	end

	// read mux and unmapped detection, reserved bits read zero
	always_comb begin
		rdata = 32'h0000_0000;
		unmapped = 1'b0;
		if (i_paddr == `PM_OFS_STATUS) begin
			rdata = status;
		end else if (i_paddr == `PM_OFS_CONFIG) begin
			rdata = cfg_q;
		end else if (i_paddr == `PM_OFS_REFRESH) begin
			rdata[RATE_W-1:0] = rate_q;
		end else begin
			unmapped = 1'b1;
		end
	end

	// one wait state; pready held low while sync reset blocks service
	always_ff @(posedge i_clock) begin
		if (!i_nrst) begin
			o_pready <= 1'b0;
			o_prdata <= 32'h0000_0000;
			o_pslverr <= 1'b0;
		end else if (o_pready) begin
			o_pready <= 1'b0;
			o_pslverr <= 1'b0;
		end else if (i_psel && i_penable && accept) begin
			o_pready <= 1'b1;
			o_prdata <= i_pwrite ? 32'h0000_0000 : rdata;
			o_pslverr <= unmapped;
		end
	end

	// only the device reset clears registers
	always_ff @(posedge i_clock) begin
		if (!i_nrst) begin
			cfg_q <= `PM_CFG_RESET;
			rate_q <= RATE_W'(`PM_REFRESH_CYCLES);
		end else if (wr_fire && i_paddr == `PM_OFS_CONFIG) begin
			cfg_q <= (cfg_q & ~wmask) | (i_pwdata & wmask);
			cfg_q[29:24] <= 6'h00;
		end else if (wr_fire && i_paddr == `PM_OFS_REFRESH) begin
			rate_q <= (rate_q & wmask[RATE_W-1:0]) == rate_q ?
				i_pwdata[RATE_W-1:0] & wmask[RATE_W-1:0] :
				(rate_q & ~wmask[RATE_W-1:0]) |
				(i_pwdata[RATE_W-1:0] & wmask[RATE_W-1:0]);
		end
	end

	// the sdram refreshes itself in self-refresh, so the interval counter is held at zero
	refresh_tick #(
		.RATE_W(RATE_W)
	) u_tick (
		.i_clock(i_clock),
		.i_nrst(i_nrst),
		.i_enable(init_done_q && state_q != sdram_pm_pkg::ST_SELF_REF),
		.i_rate(rate_q),
		.o_tick(tick)
	);

	// backlog of owed refreshes; a tick and an issue together cancel out
	always_ff @(posedge i_clock) begin
		if (!i_nrst || init_restart || !init_done_q) begin
			backlog_q <= 4'h0;
		end else if (tick && o_sdram_cmd != sdram_pm_pkg::CMD_AUTO_REFRESH) begin
			if (backlog_q != `PM_BACKLOG_MAX) begin
				backlog_q <= backlog_q + 4'h1;
			end
		end else if (!tick && o_sdram_cmd == sdram_pm_pkg::CMD_AUTO_REFRESH &&
			backlog_q != 4'h0) begin
			backlog_q <= backlog_q - 4'h1;
		end
	end

	// urgent refresh burst runs from must level down to release level
	always_ff @(posedge i_clock) begin
		if (!i_nrst) begin
			must_q <= 1'b0;
		end else if (backlog_q >= `PM_LVL_MUST) begin
			must_q <= 1'b1;
		end else if (backlog_q <= `PM_LVL_RELEASE) begin
			must_q <= 1'b0;
		end
	end

	// no halt input: debug halts leave the engine running
	// main sequencer; cke and command are set with each transition
	always_ff @(posedge i_clock) begin
		if (!i_nrst || init_restart) begin
			state_q <= sdram_pm_pkg::ST_INIT;
			cnt_q <= 16'(INIT_CYCLES - 1);
			o_sdram_cmd <= sdram_pm_pkg::CMD_NOP;
			o_sdram_clock_enable_pin <= 1'b1;
			o_mem_ack <= 1'b0;
			init_done_q <= 1'b0;
		end else begin
			o_sdram_cmd <= sdram_pm_pkg::CMD_NOP;
			o_mem_ack <= 1'b0;
			case (state_q)
			sdram_pm_pkg::ST_INIT: begin
				if (cnt_q == 16'h0000) begin
					o_sdram_cmd <= sdram_pm_pkg::CMD_LOAD_MODE;
					init_done_q <= 1'b1;
					state_q <= sdram_pm_pkg::ST_IDLE;
				end else begin
					if (cnt_q == 16'h0001) begin
						o_sdram_cmd <= sdram_pm_pkg::CMD_PRECHARGE_ALL;
					end
					cnt_q <= cnt_q - 16'h0001;
				end
			end
			sdram_pm_pkg::ST_IDLE: begin
				o_sdram_clock_enable_pin <= 1'b1;
				if (must_q) begin
					o_sdram_cmd <= sdram_pm_pkg::CMD_AUTO_REFRESH;
					cnt_q <= 16'(`PM_RFC_CYCLES - 1);
					state_q <= sdram_pm_pkg::ST_REFRESH;
				end else if (i_mem_req.valid && !i_mem_req.write && accept) begin
					o_sdram_cmd <= sdram_pm_pkg::CMD_ACCESS;
					cnt_q <= 16'(ACCESS_CYCLES - 1);
					state_q <= sdram_pm_pkg::ST_ACCESS;
				end else if (backlog_q >= `PM_LVL_NEED) begin
					o_sdram_cmd <= sdram_pm_pkg::CMD_AUTO_REFRESH;
					cnt_q <= 16'(`PM_RFC_CYCLES - 1);
					state_q <= sdram_pm_pkg::ST_REFRESH;
				end else if (i_mem_req.valid && i_mem_req.write && accept) begin
					o_sdram_cmd <= sdram_pm_pkg::CMD_ACCESS;
					cnt_q <= 16'(ACCESS_CYCLES - 1);
					state_q <= sdram_pm_pkg::ST_ACCESS;
				end else if (backlog_q != 4'h0) begin
					o_sdram_cmd <= sdram_pm_pkg::CMD_AUTO_REFRESH;
					cnt_q <= 16'(`PM_RFC_CYCLES - 1);
					state_q <= sdram_pm_pkg::ST_REFRESH;
				end else if (cfg_q[`PM_CFG_SR_BIT] && !i_mem_req.valid) begin
					o_sdram_cmd <= sdram_pm_pkg::CMD_SELF_REF_ENTRY;
					o_sdram_clock_enable_pin <= 1'b0;
					state_q <= sdram_pm_pkg::ST_SELF_REF;
				end else if (cfg_q[`PM_CFG_PDOWN_BIT] && !i_mem_req.valid) begin
					o_sdram_clock_enable_pin <= 1'b0;
					state_q <= sdram_pm_pkg::ST_PDOWN;
				end
			end
			sdram_pm_pkg::ST_ACCESS: begin
				// ack one cycle before idle so the requester can withdraw
				if (o_mem_ack) begin
					state_q <= sdram_pm_pkg::ST_IDLE;
				end else if (cnt_q == 16'h0000) begin
					o_mem_ack <= 1'b1;
				end else begin
					cnt_q <= cnt_q - 16'h0001;
				end
			end
			sdram_pm_pkg::ST_REFRESH: begin
				if (cnt_q == 16'h0000) begin
					state_q <= sdram_pm_pkg::ST_IDLE;
				end else begin
					cnt_q <= cnt_q - 16'h0001;
				end
			end
			sdram_pm_pkg::ST_PDOWN: begin
				if (backlog_q != 4'h0 || (i_mem_req.valid && accept) ||
					!cfg_q[`PM_CFG_PDOWN_BIT] || cfg_q[`PM_CFG_SR_BIT]) begin
					o_sdram_clock_enable_pin <= 1'b1;
					state_q <= sdram_pm_pkg::ST_IDLE;
				end
			end
			sdram_pm_pkg::ST_SELF_REF: begin
				// a request leaves self-refresh to be served
				if (!cfg_q[`PM_CFG_SR_BIT] || (i_mem_req.valid && accept)) begin
					o_sdram_clock_enable_pin <= 1'b1;
					cnt_q <= 16'(`PM_XSR_CYCLES - 1);
					state_q <= sdram_pm_pkg::ST_SR_EXIT;
				end
			end
			sdram_pm_pkg::ST_SR_EXIT: begin
				if (cnt_q == 16'h0000) begin
					state_q <= sdram_pm_pkg::ST_IDLE;
				end else begin
					cnt_q <= cnt_q - 16'h0001;
				end
			end
			default: begin
				state_q <= sdram_pm_pkg::ST_IDLE;
			end
			endcase
		end
	end

	// gating allowed only while idle in sleep or sync reset
	// enable and auto wake keep the clock running
	always_ff @(posedge i_clock) begin
		if (!i_nrst) begin
			o_clock_gate_ok <= 1'b0;
		end else begin
			o_clock_gate_ok <= (i_psc_state == sdram_pm_pkg::PSC_SYNC_RESET ||
				(i_psc_state == sdram_pm_pkg::PSC_AUTO_SLEEP &&
				!i_mem_req.valid && !i_psel &&
				(state_q == sdram_pm_pkg::ST_SELF_REF ||
				state_q == sdram_pm_pkg::ST_PDOWN ||
				state_q == sdram_pm_pkg::ST_IDLE)));
		end
	end

	default clocking cb @(posedge i_clock);
	endclocking
	default disable iff (!i_nrst);

	chk_pdown_cke_low: assert property (
		state_q == sdram_pm_pkg::ST_PDOWN |-> !o_sdram_clock_enable_pin)
		else $error("clock enable high in power-down");
	chk_pdown_refresh_wake: assert property (
		state_q == sdram_pm_pkg::ST_PDOWN && backlog_q != 4'h0 && !init_restart
		|=> (o_sdram_clock_enable_pin && i_mem_req.valid && accept) or
		(o_sdram_clock_enable_pin ##1
		o_sdram_cmd == sdram_pm_pkg::CMD_AUTO_REFRESH))
		else $error("due refresh not issued from power-down");
	chk_pdown_stays_low: assert property (
		state_q == sdram_pm_pkg::ST_PDOWN && backlog_q == 4'h0 &&
		!i_mem_req.valid && !init_restart && cfg_q[`PM_CFG_PDOWN_BIT] &&
		!cfg_q[`PM_CFG_SR_BIT] |=> !o_sdram_clock_enable_pin)
		else $error("clock enable rose without a request");
	chk_selfref_no_cmd: assert property (
		state_q == sdram_pm_pkg::ST_SELF_REF |-> !o_sdram_clock_enable_pin &&
		(o_sdram_cmd == sdram_pm_pkg::CMD_NOP ||
		(o_sdram_cmd == sdram_pm_pkg::CMD_SELF_REF_ENTRY &&
		$past(state_q) == sdram_pm_pkg::ST_IDLE)))
		else $error("command issued during self-refresh");
	chk_enable_no_gate: assert property (
		i_psc_state == sdram_pm_pkg::PSC_ENABLE ||
		i_psc_state == sdram_pm_pkg::PSC_AUTO_WAKE |=> !o_clock_gate_ok)
		else $error("gating allowed in enable state");
	chk_sr_after_backlog: assert property (
		state_q == sdram_pm_pkg::ST_IDLE && (backlog_q != 4'h0 ||
		i_mem_req.valid) |=> state_q != sdram_pm_pkg::ST_SELF_REF)
		else $error("self-refresh entered with work pending");
	chk_sleep_wakes: assert property (
		i_psc_state == sdram_pm_pkg::PSC_AUTO_SLEEP && i_mem_req.valid
		|=> !o_clock_gate_ok)
		else $error("request in auto sleep did not wake");
	chk_sync_no_service: assert property (
		i_psc_state == sdram_pm_pkg::PSC_SYNC_RESET && !o_pready &&
		state_q != sdram_pm_pkg::ST_ACCESS |=> !o_pready &&
		state_q != sdram_pm_pkg::ST_ACCESS)
		else $error("request serviced during sync reset");
	chk_cfg_restart_init: assert property (
		init_restart |=> state_q == sdram_pm_pkg::ST_INIT && !init_done_q)
		else $error("low byte config write did not restart init");
endmodule
`default_nettype wire

// file: test/sdram_model.sv
// behavioural sdram on the far side: follows cke and counts commands
`timescale 1ns/1ps
`default_nettype none
module sdram_model (
	input wire logic i_clock,
	input wire logic i_cke,
	input wire sdram_pm_pkg::sdram_cmd_t i_cmd,
	output var int o_refreshes,
	output var int o_faults
);
	// both counters start at zero as two-state ints, one driver each
	logic in_sr = 1'b0;
	logic cke_q = 1'b1;
	// the part holds itself in self-refresh until cke rises again
	always @(posedge i_clock) begin
		cke_q <= i_cke;
		if (i_cmd == sdram_pm_pkg::CMD_SELF_REF_ENTRY)
			in_sr <= 1'b1;
		else if (i_cke && !cke_q)
			in_sr <= 1'b0;
		if (i_cmd == sdram_pm_pkg::CMD_AUTO_REFRESH)
			o_refreshes <= o_refreshes + 1;
		// commands lost
		// a command under self-refresh or a frozen clock would be dropped
		if (i_cmd != sdram_pm_pkg::CMD_NOP &&
			i_cmd != sdram_pm_pkg::CMD_SELF_REF_ENTRY && (in_sr || !cke_q))
			o_faults <= o_faults + 1;
	end
endmodule
`default_nettype wire

// file: test/test_sdram_ctrl_power_management.sv
// self-checking bench for the memory controller power management block
`timescale 1ns/1ps
`default_nettype none
`include "sdram_pm_params.svh"
module test_sdram_ctrl_power_management;
	logic i_clock, i_nrst, psel, penable, pwrite, pready, pslverr, er;
	logic ack, cke, gate_ok;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [3:0] pstrb;
	sdram_pm_pkg::psc_state_t power_sleep_ctrl;
	sdram_pm_pkg::mem_req_t req;
	sdram_pm_pkg::sdram_cmd_t cmd;
	int mismatches, n_checks, cyc, sr_at, ack_at, n_ref, faults, lat;

	// short init so restarts finish quickly
	sdram_pm_ctrl #(.INIT_CYCLES(20)) sdram_pm_ctrl_inst (
		.i_clock(i_clock), .i_nrst(i_nrst), .i_psel(psel),
		.i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
		.i_pwdata(pwdata), .i_pstrb(pstrb), .o_pready(pready),
		.o_prdata(prdata), .o_pslverr(pslverr), .i_psc_state(power_sleep_ctrl),
		.i_mem_req(req), .o_mem_ack(ack),
		.o_sdram_clock_enable_pin(cke), .o_sdram_cmd(cmd),
		.o_clock_gate_ok(gate_ok)
	);
	sdram_model sdram_model_inst (
		.i_clock(i_clock), .i_cke(cke), .i_cmd(cmd),
		.o_refreshes(n_ref), .o_faults(faults)
	);

	// clock and a cycle stamp of self-refresh entries and acks
	// clock never stopped
	initial begin
		i_clock = 1'b0;
		forever #12.5 i_clock = ~i_clock;
	end
	always @(posedge i_clock) begin
		cyc++;
		if (cmd == sdram_pm_pkg::CMD_SELF_REF_ENTRY)
			sr_at = cyc;
		if (ack === 1'b1)
			ack_at = cyc;
	end

	task print_verdict;
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	task chk(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task hung(input string what);
		mismatches++;
		$display("Error %s expected answer seen timeout", what);
		print_verdict();
	endtask

	// apb master: request held until pready is sampled high
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d,
		input logic [3:0] s);
		int n;
		@(posedge i_clock);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		pstrb <= s;
		@(posedge i_clock);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge i_clock);
			n++;
			if (n > 300)
				hung("apb pready");
		end while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// memory request: valid drops at the edge that sees ack
	task mem(input logic w);
		int n, t;
		@(posedge i_clock);
		req <= '{valid: 1'b1, write: w};
		n = 0;
		t = 0;
		do begin
			@(posedge i_clock);
			n++;
			if (cmd == sdram_pm_pkg::CMD_ACCESS)
				t = n;
			if (n > 300)
				hung("memory ack");
		end while (ack !== 1'b1);
		lat = n - t;
		req.valid <= 1'b0;
	endtask

	task wait_cke(input logic v);
		int n;
		n = 0;
		while (cke !== v) begin
			@(posedge i_clock);
			n++;
			if (n > 300)
				hung("clock enable");
		end
		chk("clock enable", cke, v);
	endtask

	task wait_sr(input int old);
		int n;
		n = 0;
		while (sr_at == old) begin
			@(posedge i_clock);
			n++;
			if (n > 300)
				hung("self-refresh entry");
		end
	endtask

	task t_regs;
		apb(0, `PM_OFS_STATUS, 0, 0);
		chk("psc state", 32'(rd[13:12]), 32'h0);
		apb(0, `PM_OFS_CONFIG, 0, 0);
		chk("config reset", rd, 32'h0);
		apb(0, `PM_OFS_REFRESH, 0, 0);
		chk("refresh reset", rd, 32'h0000_0271);
		apb(0, 12'h00c, 0, 0);
		chk("unmapped error", 32'(er), 32'h1);
		chk("unmapped data", rd, 32'h0);
		// a short interval makes refreshes frequent
		apb(1, `PM_OFS_REFRESH, 32'h0000_0028, 4'hf);
	endtask

	task t_pdown;
		int h, r0;
		apb(1, `PM_OFS_CONFIG, 32'h4000_0000, 4'h8);
		wait_cke(1'b0);
		r0 = n_ref;
		h = 0;
		repeat (400) begin
			@(posedge i_clock);
			h += int'(cke);
		end
		chk("refreshes in power-down", 32'(n_ref > r0), 32'h1);
		chk("cke high time", 32'(h <= (n_ref - r0) * 8), 32'h1);
		mem(1'b0);
		chk("cke at ack", 32'(cke), 32'h1);
		chk("access latency", lat, 32'(`PM_ACCESS_CYCLES));
		apb(1, `PM_OFS_CONFIG, 32'h0, 4'h8);
	endtask

	task t_self_ref;
		int s0;
		s0 = sr_at;
		// the request is raised while an access is still outstanding
		fork
			mem(1'b0);
			apb(1, `PM_OFS_CONFIG, 32'h8000_0000, 4'h8);
		join
		wait_sr(s0);
		chk("entry after ack", 32'(sr_at > ack_at), 32'h1);
		apb(0, `PM_OFS_STATUS, 0, 0);
		chk("state self-refresh", 32'(rd[2:0]), 32'h5);
		chk("backlog drained", 32'(rd[11:8]), 32'h0);
		chk("cke in self-refresh", 32'(rd[3]), 32'h0);
	endtask

	task t_sleep;
		int s0;
		power_sleep_ctrl <= sdram_pm_pkg::PSC_AUTO_SLEEP;
		repeat (3) @(posedge i_clock);
		chk("gate ok in sleep", 32'(gate_ok), 32'h1);
		s0 = sr_at;
		mem(1'b1);
		chk("served in sleep", lat, 32'(`PM_ACCESS_CYCLES));
		wait_sr(s0);
		chk("back to self-refresh", 32'(sr_at > ack_at), 32'h1);
		repeat (3) @(posedge i_clock);
		chk("gate ok again", 32'(gate_ok), 32'h1);
		apb(0, `PM_OFS_CONFIG, 0, 0);
		chk("register read in sleep", rd, 32'h8000_0000);
		power_sleep_ctrl <= sdram_pm_pkg::PSC_AUTO_WAKE;
		apb(1, `PM_OFS_CONFIG, 32'h0, 4'h8);
		wait_cke(1'b1);
		chk("gate ok after wake", 32'(gate_ok), 32'h0);
	endtask

	task t_sync;
		int s0, p;
		s0 = sr_at;
		apb(1, `PM_OFS_CONFIG, 32'h8000_0000, 4'h8);
		wait_sr(s0);
		power_sleep_ctrl <= sdram_pm_pkg::PSC_SYNC_RESET;
		p = 0;
		// both requests must sit unanswered until enable returns
		fork
			apb(0, `PM_OFS_CONFIG, 0, 0);
			mem(1'b0);
			begin
				repeat (30) begin
					@(posedge i_clock);
					p += int'(pready) + int'(ack);
				end
				power_sleep_ctrl <= sdram_pm_pkg::PSC_ENABLE;
			end
		join
		chk("service in sync reset", p, 32'h0);
		chk("config kept", rd, 32'h8000_0000);
		apb(1, `PM_OFS_CONFIG, 32'h0, 4'h8);
		wait_cke(1'b1);
	endtask

	task t_init;
		apb(1, `PM_OFS_CONFIG, 32'h0000_0001, 4'h1);
		apb(0, `PM_OFS_STATUS, 0, 0);
		chk("init restarted", 32'(rd[4]), 32'h0);
		apb(0, `PM_OFS_CONFIG, 0, 0);
		chk("config stored", rd, 32'h0000_0001);
		repeat (40) @(posedge i_clock);
		apb(1, `PM_OFS_CONFIG, 32'h8000_0000, 4'h8);
		apb(0, `PM_OFS_STATUS, 0, 0);
		chk("init kept", 32'(rd[4]), 32'h1);
	endtask

	// reset, then every scenario in turn
	initial begin
		{i_nrst, psel, penable, pwrite, pwdata, pstrb} = '0;
		paddr = 12'h000;
		power_sleep_ctrl = sdram_pm_pkg::PSC_ENABLE;
		req = '{valid: 1'b0, write: 1'b0};
		{mismatches, n_checks} = '0;
		repeat (8) @(posedge i_clock);
		i_nrst <= 1'b1;
		t_regs();
		t_pdown();
		t_self_ref();
		t_sleep();
		t_sync();
		t_init();
		chk("lost commands", faults, 32'h0);
		print_verdict();
	end
endmodule
`default_nettype wire
